/* src/power_mode_ctrl.sv */
// Power-mode controller: off state, wake, sub-modes, supply-fail warning
// Overview of operation
// - Off state wakes on five causes (pin, analog, field, ext reset, debug); brownout also forces wake
// - Wake from off performs system reset
// - Off powers core down, kills tasks
// - RAM sections retained per setting
// - Debug mode only emulates off state
// - Power-on reset starts in on state
// - Sub-modes apply only when all idle
// - Fixed-latency task forces base resources
// - Low-power task selects automatic management
// - Low-power sub-mode default on entry
// - Reset cause register records wake source
// - Brownout holds system in reset
// - Supply-fail comparator never resets system
// - Enabled comparator raises warning below threshold
// - Warning on enable-while-low or threshold rewrite
// - Warning blocks nonvolatile writes
// - Comparator inactive off or clock stopped
// - Linear regulator default, switcher by register
// - Tasks at 078/07C, event at 108
// - Interrupt enable set, readable state
// - Reset cause accumulates, write-one clears
`timescale 1ns/1ns
module power_mode_ctrl #(
  parameter int RAM_SECTIONS = 32,
  parameter int RESET_CYCLES = power_mode_pkg::WAKE_RESET_CYCLES
) (
  input wire logic clk_i, // system clock 20 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic [11:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after read
  input wire logic pin_detect_i, // pin-detect wake
  input wire logic analog_compare_wake_i, // analog compare wake
  input wire logic field_sense_i, // field-sense wake
  input wire logic ext_reset_i, // external reset request
  input wire logic debug_mode_i, // debug interface mode
  input wire logic fast_clock_run_i, // fast clock running
  input wire logic cpu_idle_i, // CPU idle
  input wire logic periph_idle_i, // all peripherals idle
  input wire logic below_thresh_i, // comparator: supply below threshold
  input wire logic brownout_i, // brownout indication
  output logic sys_reset_o, // system reset request
  output logic core_power_o, // core domain powered
  output logic task_abort_o, // terminate running tasks
  output logic [RAM_SECTIONS-1:0] ram_power_o, // per-section RAM power
  output logic base_force_o, // base resources forced on
  output logic auto_manage_o, // automatic supply management
  output logic switcher_on_o, // switching regulator selected
  output logic cmp_active_o, // comparator powered
  output logic [power_mode_pkg::THRESH_WIDTH-1:0] fail_threshold_o, // threshold code
  output logic nv_write_block_o, // block nonvolatile writes
  output logic warn_irq_o // supply-fail warning interrupt
);
  power_mode_pkg::mode_t state_reg;
  power_mode_pkg::mode_t state_next;
  logic [7:0] wake_cnt_reg;
  logic [4:0] sync_vec;
  logic pin_s, ana_s, fld_s, below_s, brown_s;
  logic wake_any;
  logic fixed_lat_reg;
  logic warn_event_reg;
  logic int_en_reg;
  logic [power_mode_pkg::CAUSE_WIDTH-1:0] cause_reg;
  logic fail_en_reg;
  logic [power_mode_pkg::THRESH_WIDTH-1:0] thresh_reg;
  logic switcher_reg;
  logic [RAM_SECTIONS-1:0] ram_retain_reg;
  logic emulated_reg;
  logic warn_pulse;
  logic nv_block;
  logic thresh_wr;
  logic off_req;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  level_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({brownout_i, below_thresh_i, field_sense_i, analog_compare_wake_i,
      pin_detect_i}),
    .sync_o(sync_vec)
  );
  assign {brown_s, below_s, fld_s, ana_s, pin_s} = sync_vec;

  assign wake_any = pin_s || ana_s || fld_s || ext_reset_i;
  assign off_req = wr_i && hit(addr_i, power_mode_pkg::OFF_OFF_REQUEST) && wdata_i[0];
  assign thresh_wr = wr_i && hit(addr_i, power_mode_pkg::OFF_FAIL_CONFIG);

  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      power_mode_pkg::ST_ON: begin
        if (off_req && !debug_mode_i) begin
          state_next = power_mode_pkg::ST_OFF;
        end
      end
      power_mode_pkg::ST_OFF: begin
        if (wake_any || debug_mode_i) begin
          state_next = power_mode_pkg::ST_WAKE;
        end
      end
      power_mode_pkg::ST_WAKE: begin
        if (wake_cnt_reg == 8'(RESET_CYCLES - 1) && !brown_s) begin
          state_next = power_mode_pkg::ST_ON;
        end
      end
      default: state_next = power_mode_pkg::ST_ON;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= power_mode_pkg::ST_ON;
    end else if (brown_s) begin
      state_reg <= power_mode_pkg::ST_WAKE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt_reg <= 8'h00;
    end else if (state_reg != power_mode_pkg::ST_WAKE || brown_s) begin
      wake_cnt_reg <= 8'h00;
    end else if (wake_cnt_reg != 8'(RESET_CYCLES - 1)) begin
      wake_cnt_reg <= wake_cnt_reg + 8'h01;
    end
  end

  // Emulated off: everything stays powered, flag only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      emulated_reg <= 1'b0;
    end else if (off_req && debug_mode_i) begin
      emulated_reg <= 1'b1;
    end else if (state_reg == power_mode_pkg::ST_WAKE) begin
      emulated_reg <= 1'b0;
    end
  end

  // Power and reset outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_reset_o <= 1'b0;
      core_power_o <= 1'b1;
      task_abort_o <= 1'b0;
    end else begin
      sys_reset_o <= (state_next == power_mode_pkg::ST_WAKE) || brown_s;
      core_power_o <= (state_next != power_mode_pkg::ST_OFF);
      task_abort_o <= (state_next == power_mode_pkg::ST_OFF);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_power_o <= '1;
    end else if (state_next == power_mode_pkg::ST_OFF) begin
      ram_power_o <= ram_retain_reg;
    end else begin
      ram_power_o <= '1;
    end
  end

  // Sub-mode select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fixed_lat_reg <= 1'b0;
    end else if (state_reg != power_mode_pkg::ST_ON) begin
      fixed_lat_reg <= 1'b0;
    end else if (wr_i && wdata_i[0] && hit(addr_i, power_mode_pkg::OFF_FIXED_LAT_TASK)) begin
      fixed_lat_reg <= 1'b1;
    end else if (wr_i && wdata_i[0] && hit(addr_i, power_mode_pkg::OFF_LOW_POWER_TASK)) begin
      fixed_lat_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_force_o <= 1'b0;
      auto_manage_o <= 1'b0;
    end else begin
      base_force_o <= (state_reg == power_mode_pkg::ST_ON) && cpu_idle_i && periph_idle_i
        && fixed_lat_reg;
      auto_manage_o <= (state_reg == power_mode_pkg::ST_ON) && cpu_idle_i && periph_idle_i
        && !fixed_lat_reg;
    end
  end

  // Supply-fail comparator; only warns, never resets
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_active_o <= 1'b0;
    end else begin
      cmp_active_o <= (state_reg == power_mode_pkg::ST_ON) && fast_clock_run_i;
    end
  end

  fail_monitor u_fail (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .active_i(cmp_active_o),
    .enable_i(fail_en_reg),
    .thresh_write_i(thresh_wr),
    .below_i(below_s),
    .warn_pulse_o(warn_pulse),
    .block_nv_o(nv_block)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_write_block_o <= 1'b0;
    end else begin
      nv_write_block_o <= nv_block;
    end
  end

  // Warning event flag, set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_event_reg <= 1'b0;
    end else if (warn_pulse) begin
      warn_event_reg <= 1'b1;
    end else if (wr_i && hit(addr_i, power_mode_pkg::OFF_WARN_EVENT)) begin
      warn_event_reg <= wdata_i[0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_en_reg <= 1'b0;
    end else if (wr_i && hit(addr_i, power_mode_pkg::OFF_INT_ENABLE_SET)
        && wdata_i[power_mode_pkg::INT_WARN_BIT]) begin
      int_en_reg <= 1'b1;
    end else if (wr_i && hit(addr_i, power_mode_pkg::OFF_INT_ENABLE_CLR)
        && wdata_i[power_mode_pkg::INT_WARN_BIT]) begin
      int_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_irq_o <= 1'b0;
    end else begin
      warn_irq_o <= warn_event_reg && int_en_reg;
    end
  end

  // Reset cause: sticky, write-one clears, set wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_reg <= '0;
    end else begin
      for (int i = 0; i < power_mode_pkg::CAUSE_WIDTH; i++) begin
        if (wr_i && hit(addr_i, power_mode_pkg::OFF_RESET_CAUSE) && wdata_i[i]) begin
          cause_reg[i] <= 1'b0;
        end
      end
      if (state_reg == power_mode_pkg::ST_OFF) begin
        if (pin_s) cause_reg[power_mode_pkg::CAUSE_PIN_DETECT] <= 1'b1;
        if (ana_s) cause_reg[power_mode_pkg::CAUSE_ANALOG] <= 1'b1;
        if (fld_s) cause_reg[power_mode_pkg::CAUSE_FIELD] <= 1'b1;
        if (debug_mode_i) cause_reg[power_mode_pkg::CAUSE_DEBUG] <= 1'b1;
      end
      if (ext_reset_i) cause_reg[power_mode_pkg::CAUSE_EXT_RESET] <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fail_en_reg <= 1'b0;
      thresh_reg <= power_mode_pkg::THRESH_RESET;
    end else if (thresh_wr) begin
      fail_en_reg <= wdata_i[power_mode_pkg::CFG_ENABLE_BIT];
      thresh_reg <= wdata_i[power_mode_pkg::CFG_THRESH_LSB +: power_mode_pkg::THRESH_WIDTH];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switcher_reg <= 1'b0;
    end else if (wr_i && hit(addr_i, power_mode_pkg::OFF_SWITCHER_ENABLE)) begin
      switcher_reg <= wdata_i[0];
    end
  end

  // Reset only by the async power-up reset, not by wake resets
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_retain_reg <= RAM_SECTIONS'(power_mode_pkg::RAM_RETAIN_RESET);
    end else if (wr_i && hit(addr_i, power_mode_pkg::OFF_RAM_RETAIN)) begin
      ram_retain_reg <= wdata_i[RAM_SECTIONS-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switcher_on_o <= 1'b0;
      fail_threshold_o <= power_mode_pkg::THRESH_RESET;
    end else begin
      switcher_on_o <= switcher_reg;
      fail_threshold_o <= thresh_reg;
    end
  end

  // Read port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        power_mode_pkg::OFF_WARN_EVENT: rdata_o <= {31'h0, warn_event_reg};
        power_mode_pkg::OFF_INT_ENABLE_SET,
        power_mode_pkg::OFF_INT_ENABLE_CLR: rdata_o <= {31'h0, int_en_reg};
        power_mode_pkg::OFF_RESET_CAUSE: rdata_o <= 32'(cause_reg);
        power_mode_pkg::OFF_STATUS: rdata_o <= {27'h0, switcher_reg, emulated_reg,
          cmp_active_o, below_s, fixed_lat_reg};
        power_mode_pkg::OFF_FAIL_CONFIG: rdata_o <= 32'({thresh_reg, fail_en_reg});
        power_mode_pkg::OFF_SWITCHER_ENABLE: rdata_o <= {31'h0, switcher_reg};
        power_mode_pkg::OFF_RAM_RETAIN: rdata_o <= 32'(ram_retain_reg);
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule

/* src/power_mode_pkg.sv */
// Shared constants for the power-mode controller
package power_mode_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_FIXED_LAT_TASK = 12'h078;
  localparam logic [11:0] OFF_LOW_POWER_TASK = 12'h07c;
  localparam logic [11:0] OFF_WARN_EVENT = 12'h108;
  localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFF_INT_ENABLE_CLR = 12'h308;
  localparam logic [11:0] OFF_RESET_CAUSE = 12'h400;
  localparam logic [11:0] OFF_STATUS = 12'h404;
  localparam logic [11:0] OFF_OFF_REQUEST = 12'h500;
  localparam logic [11:0] OFF_FAIL_CONFIG = 12'h510;
  localparam logic [11:0] OFF_SWITCHER_ENABLE = 12'h578;
  localparam logic [11:0] OFF_RAM_RETAIN = 12'h900;
  // Interrupt enable field
  localparam int INT_WARN_BIT = 0;
  // Reset cause fields
  localparam int CAUSE_PIN_DETECT = 0;
  localparam int CAUSE_ANALOG = 1;
  localparam int CAUSE_FIELD = 2;
  localparam int CAUSE_DEBUG = 3;
  localparam int CAUSE_EXT_RESET = 4;
  localparam int CAUSE_WIDTH = 5;
  // Fail config fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_THRESH_LSB = 1;
  localparam int THRESH_WIDTH = 4;
  // Status fields
  localparam int STAT_SUBMODE_BIT = 0;
  localparam int STAT_BELOW_BIT = 1;
  localparam int STAT_CMP_ACTIVE_BIT = 2;
  localparam int STAT_EMULATED_BIT = 3;
  localparam int STAT_SWITCHER_BIT = 4;
  // Reset values
  localparam logic [31:0] RAM_RETAIN_RESET = 32'hffff_ffff;
  localparam logic [THRESH_WIDTH-1:0] THRESH_RESET = 4'h0;
  // Wake-reset pulse length
  localparam int WAKE_RESET_NS = 500;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_RESET_CYCLES = (WAKE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_ON = 3'b001,
    ST_OFF = 3'b010,
    ST_WAKE = 3'b100
  } mode_t;
endpackage

/* src/level_sync.sv */
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic [WIDTH-1:0] async_i, // raw levels
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] first_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_reg <= '0;
      sync_o <= '0;
    end else begin
      first_reg <= async_i;
      sync_o <= first_reg;
    end
  end
endmodule

/* src/fail_monitor.sv */
// Supply-fail warning detector
`timescale 1ns/1ns
module fail_monitor (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic active_i, // comparator powered
  input wire logic enable_i, // warning enabled
  input wire logic thresh_write_i, // threshold rewritten
  input wire logic below_i, // synchronised compare result
  output logic warn_pulse_o, // one-cycle warning event
  output logic block_nv_o // block nonvolatile writes
);
  logic armed_reg;
  logic prev_below_reg;
  logic thresh_seen_reg;
  logic live;
  assign live = active_i && enable_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_reg <= 1'b0;
      prev_below_reg <= 1'b0;
      thresh_seen_reg <= 1'b0;
    end else begin
      armed_reg <= live;
      prev_below_reg <= below_i;
      // Rewrite judged a cycle late, against the new enable
      thresh_seen_reg <= thresh_write_i;
    end
  end
  // Falling supply, fresh enable while low, or threshold rewritten
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_pulse_o <= 1'b0;
    end else begin
      warn_pulse_o <= live && below_i && (!prev_below_reg || !armed_reg || thresh_seen_reg);
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_nv_o <= 1'b0;
    end else begin
      block_nv_o <= live && below_i;
    end
  end
endmodule

/* testbench/power_mode_chk.sv */
// Port-level assertions for the power-mode controller
`timescale 1ns/1ns
module power_mode_chk #(
  parameter int RESET_CYCLES = 10
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic [11:0] addr_i, // address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [31:0] rdata_o, // read data
  input wire logic pin_detect_i, // wake
  input wire logic analog_compare_wake_i, // wake
  input wire logic field_sense_i, // wake
  input wire logic ext_reset_i, // reset request
  input wire logic debug_mode_i, // debug mode
  input wire logic fast_clock_run_i, // fast clock
  input wire logic cpu_idle_i, // cpu idle
  input wire logic periph_idle_i, // periph idle
  input wire logic below_thresh_i, // below threshold
  input wire logic brownout_i, // brownout
  input wire logic sys_reset_o, // system reset
  input wire logic core_power_o, // core power
  input wire logic task_abort_o, // task abort
  input wire logic base_force_o, // fixed latency
  input wire logic auto_manage_o, // low power
  input wire logic cmp_active_o, // comparator on
  input wire logic nv_write_block_o // nv block
);
  logic [3:0] quiet_q;
  logic wake_any;
  assign wake_any = pin_detect_i | analog_compare_wake_i | field_sense_i | ext_reset_i
    | debug_mode_i | brownout_i;
  // Cycles since any wake or reset cause was seen, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_q <= 4'hf;
    end else if (wake_any) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  off_enter_a: assert property (
    wr_i && addr_i == power_mode_pkg::OFF_OFF_REQUEST && wdata_i[0] && !debug_mode_i
    && core_power_o && !sys_reset_o && quiet_q == 4'hf |=> ##1 !core_power_o && task_abort_o)
    else $error("off request did not power down the core");
  debug_emul_a: assert property (
    wr_i && addr_i == power_mode_pkg::OFF_OFF_REQUEST && wdata_i[0] && debug_mode_i
    && core_power_o && !sys_reset_o |=> core_power_o [*3])
    else $error("emulated off dropped core power");
  wake_reset_a: assert property (
    $rose(core_power_o) |-> sys_reset_o || $past(sys_reset_o))
    else $error("left off state without reset");
  reset_len_a: assert property (
    $rose(sys_reset_o) && !brownout_i |-> sys_reset_o [*8])
    else $error("wake reset too short");
  wake_cause_a: assert property (
    $rose(sys_reset_o) |-> quiet_q <= 4'h5)
    else $error("reset without a wake cause");
  brownout_a: assert property (
    brownout_i [*4] |-> sys_reset_o)
    else $error("brownout did not hold reset");
  idle_only_a: assert property (
    (!cpu_idle_i || !periph_idle_i) [*3] |-> !base_force_o && !auto_manage_o)
    else $error("sub-mode active while busy");
  fixed_lat_a: assert property (
    wr_i && addr_i == power_mode_pkg::OFF_FIXED_LAT_TASK && wdata_i[0] && core_power_o
    && !sys_reset_o && quiet_q == 4'hf && cpu_idle_i && periph_idle_i
    ##1 (cpu_idle_i && periph_idle_i) [*2] |-> base_force_o && !auto_manage_o)
    else $error("fixed latency not selected");
  low_pwr_a: assert property (
    wr_i && addr_i == power_mode_pkg::OFF_LOW_POWER_TASK && wdata_i[0] && core_power_o
    && !sys_reset_o && quiet_q == 4'hf && cpu_idle_i && periph_idle_i
    ##1 (cpu_idle_i && periph_idle_i) [*2] |-> auto_manage_o && !base_force_o)
    else $error("low power not selected");
  cmp_off_a: assert property (
    (!fast_clock_run_i || !core_power_o) [*2] |-> !cmp_active_o)
    else $error("comparator active without clock or power");
  nv_block_a: assert property (
    (!below_thresh_i) [*5] |-> !nv_write_block_o)
    else $error("nv writes blocked above threshold");
  rdata_zero_a: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule
bind power_mode_ctrl power_mode_chk #(.RESET_CYCLES(RESET_CYCLES)) chk_i (.*);

/* testbench/wake_source_model.sv */
// Wake-source peripherals: hold one wake level for a few cycles
`timescale 1ns/1ns
module wake_source_model (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic fire_i, // start a wake level
  input wire logic [1:0] sel_i, // 0 pin, 1 analog, 2 field
  output logic pin_detect_o, // pin-detect level
  output logic analog_wake_o, // analog compare level
  output logic field_sense_o // field-sense level
);
  logic [2:0] left_q;
  logic [1:0] sel_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q <= 3'h0;
      sel_q <= 2'h0;
    end else if (fire_i) begin
      left_q <= 3'h4;
      sel_q <= sel_i;
    end else if (left_q != 3'h0) begin
      left_q <= left_q - 3'h1;
    end
  end
  assign pin_detect_o = left_q != 3'h0 && sel_q == 2'h0;
  assign analog_wake_o = left_q != 3'h0 && sel_q == 2'h1;
  assign field_sense_o = left_q != 3'h0 && sel_q == 2'h2;
endmodule

/* testbench/power_mode_ctrl_tb.sv */
// Self-checking bench for the power-mode controller
`timescale 1ns/1ns
module power_mode_ctrl_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_reset_i = 1'b0;
  logic debug_mode_i = 1'b0;
  logic fast_clock_run_i = 1'b1;
  logic cpu_idle_i = 1'b1;
  logic periph_idle_i = 1'b1;
  logic below_thresh_i = 1'b0;
  logic brownout_i = 1'b0;
  logic fire = 1'b0;
  logic [1:0] sel = 2'h0;
  logic pin_detect, analog_wake, field_sense;
  logic [31:0] rdata_o, ram_power_o;
  logic sys_reset_o, core_power_o, task_abort_o, base_force_o, auto_manage_o;
  logic switcher_on_o, cmp_active_o, nv_write_block_o, warn_irq_o;
  logic [3:0] fail_threshold_o;
  int bad_count = 0;
  int n_tests = 0;
  always #25 clk_i = ~clk_i;
  wake_source_model wake_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .sel_i(sel),
    .pin_detect_o(pin_detect), .analog_wake_o(analog_wake), .field_sense_o(field_sense));
  power_mode_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_detect_i(pin_detect),
    .analog_compare_wake_i(analog_wake), .field_sense_i(field_sense),
    .ext_reset_i(ext_reset_i), .debug_mode_i(debug_mode_i),
    .fast_clock_run_i(fast_clock_run_i), .cpu_idle_i(cpu_idle_i),
    .periph_idle_i(periph_idle_i), .below_thresh_i(below_thresh_i), .brownout_i(brownout_i),
    .sys_reset_o(sys_reset_o), .core_power_o(core_power_o), .task_abort_o(task_abort_o),
    .ram_power_o(ram_power_o), .base_force_o(base_force_o), .auto_manage_o(auto_manage_o),
    .switcher_on_o(switcher_on_o), .cmp_active_o(cmp_active_o),
    .fail_threshold_o(fail_threshold_o), .nv_write_block_o(nv_write_block_o),
    .warn_irq_o(warn_irq_o));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata_o);
  endtask
  task automatic wait_rst(input logic v);
    int i = 0;
    while (sys_reset_o !== v && i < 50) begin
      cyc(1);
      i++;
    end
    chk("sys_reset", 32'(v), 32'(sys_reset_o));
  endtask
  task automatic t_reset;
    chk("core_power", 32'h1, 32'(core_power_o));
    chk("ram_power", 32'hffff_ffff, ram_power_o);
    chk("auto_manage", 32'h1, 32'(auto_manage_o));
    chk("switcher", 32'h0, 32'(switcher_on_o));
    rchk(power_mode_pkg::OFF_RESET_CAUSE, 32'h0);
    rchk(power_mode_pkg::OFF_RAM_RETAIN, power_mode_pkg::RAM_RETAIN_RESET);
    rchk(12'h7f0, 32'h0);
  endtask
  task automatic t_submode;
    wr(power_mode_pkg::OFF_FIXED_LAT_TASK, 32'h1);
    cyc(2);
    chk("base_force", 32'h1, 32'(base_force_o));
    @(posedge clk_i) cpu_idle_i <= 1'b0;
    cyc(3);
    chk("busy base_force", 32'h0, 32'(base_force_o));
    @(posedge clk_i) cpu_idle_i <= 1'b1;
    wr(power_mode_pkg::OFF_LOW_POWER_TASK, 32'h1);
    cyc(2);
    chk("auto_manage", 32'h1, 32'(auto_manage_o));
    wr(power_mode_pkg::OFF_SWITCHER_ENABLE, 32'h1);
    cyc(2);
    chk("switcher", 32'h1, 32'(switcher_on_o));
  endtask
  task automatic t_warn;
    wr(power_mode_pkg::OFF_FAIL_CONFIG, 32'h15);
    wr(power_mode_pkg::OFF_INT_ENABLE_SET, 32'h1);
    rchk(power_mode_pkg::OFF_INT_ENABLE_SET, 32'h1);
    chk("threshold", 32'ha, 32'(fail_threshold_o));
    chk("cmp_active", 32'h1, 32'(cmp_active_o));
    @(posedge clk_i) below_thresh_i <= 1'b1;
    cyc(6);
    rchk(power_mode_pkg::OFF_WARN_EVENT, 32'h1);
    chk("nv_block", 32'h1, 32'(nv_write_block_o));
    chk("warn_irq", 32'h1, 32'(warn_irq_o));
    chk("no reset", 32'h0, 32'(sys_reset_o));
    wr(power_mode_pkg::OFF_INT_ENABLE_CLR, 32'h1);
    wr(power_mode_pkg::OFF_WARN_EVENT, 32'h0);
    wr(power_mode_pkg::OFF_FAIL_CONFIG, 32'h14);
    cyc(3);
    chk("irq off", 32'h0, 32'(warn_irq_o));
    chk("nv free", 32'h0, 32'(nv_write_block_o));
    rchk(power_mode_pkg::OFF_WARN_EVENT, 32'h0);
    wr(power_mode_pkg::OFF_FAIL_CONFIG, 32'h15);
    cyc(3);
    rchk(power_mode_pkg::OFF_WARN_EVENT, 32'h1);
    wr(power_mode_pkg::OFF_WARN_EVENT, 32'h0);
    wr(power_mode_pkg::OFF_FAIL_CONFIG, 32'h1f);
    cyc(3);
    rchk(power_mode_pkg::OFF_WARN_EVENT, 32'h1);
    @(posedge clk_i) below_thresh_i <= 1'b0;
    fast_clock_run_i <= 1'b0;
    cyc(4);
    chk("cmp idle", 32'h0, 32'(cmp_active_o));
    @(posedge clk_i) fast_clock_run_i <= 1'b1;
  endtask
  task automatic t_off;
    int bitpos [5] = '{0, 1, 2, 4, 3};
    logic [31:0] exp_cause = 32'h0;
    wr(power_mode_pkg::OFF_RAM_RETAIN, 32'h0000_00f0);
    for (int k = 0; k < 5; k++) begin
      wr(power_mode_pkg::OFF_FIXED_LAT_TASK, 32'h1);
      wr(power_mode_pkg::OFF_OFF_REQUEST, 32'h1);
      cyc(12);
      chk("off core", 32'h0, 32'(core_power_o));
      chk("off abort", 32'h1, 32'(task_abort_o));
      chk("off ram", 32'h0000_00f0, ram_power_o);
      chk("off cmp", 32'h0, 32'(cmp_active_o));
      @(posedge clk_i);
      if (k == 3) begin
        ext_reset_i <= 1'b1;
      end else if (k == 4) begin
        debug_mode_i <= 1'b1;
      end else begin
        fire <= 1'b1;
        sel <= 2'(k);
      end
      @(posedge clk_i);
      ext_reset_i <= 1'b0;
      fire <= 1'b0;
      debug_mode_i <= 1'b0;
      wait_rst(1'b1);
      wait_rst(1'b0);
      cyc(2);
      chk("woken", 32'h1, 32'(core_power_o));
      chk("default low power", 32'h1, 32'(auto_manage_o));
      exp_cause = exp_cause | (32'h1 << bitpos[k]);
      rchk(power_mode_pkg::OFF_RESET_CAUSE, exp_cause);
      rchk(power_mode_pkg::OFF_RAM_RETAIN, 32'h0000_00f0);
      if (k % 2 == 1) begin
        wr(power_mode_pkg::OFF_RESET_CAUSE, exp_cause);
        exp_cause = 32'h0;
        rchk(power_mode_pkg::OFF_RESET_CAUSE, 32'h0);
      end
    end
  endtask
  task automatic t_debug_brown;
    @(posedge clk_i) debug_mode_i <= 1'b1;
    wr(power_mode_pkg::OFF_OFF_REQUEST, 32'h1);
    cyc(4);
    chk("emulated core", 32'h1, 32'(core_power_o));
    rchk(power_mode_pkg::OFF_STATUS, 32'h0000_001c);
    @(posedge clk_i) debug_mode_i <= 1'b0;
    brownout_i <= 1'b1;
    cyc(6);
    chk("brownout reset", 32'h1, 32'(sys_reset_o));
    @(posedge clk_i) brownout_i <= 1'b0;
    wait_rst(1'b0);
  endtask
  initial begin
    #(50 * 6000);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    t_reset;
    t_submode;
    t_warn;
    t_off;
    t_debug_brown;
    cyc(2);
    stop_test;
  end
endmodule
